// ===== logic/ats_blink.sv
// trigger indicator driver: blink, steady on or off
`timescale 1ns/1ps
`default_nettype none
module ats_blink
	import ats_pkg::*;
#(
	parameter int HALF = ATS_BLINK_CYC
) (
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic resetn_in,
	// mode
	input  wire logic blink_in,
	input  wire logic on_in,
	// lamp
	output logic      led_out
);
	logic [31:0] cnt_q;
	logic        ph_q;
	wire         wrap = (cnt_q >= 32'(HALF - 1));

	// free phase counter; led registered
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			cnt_q   <= 32'h0000_0000;
			ph_q    <= 1'b0;
			led_out <= 1'b0;
		end else begin
			cnt_q   <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
			ph_q    <= wrap ? ~ph_q : ph_q;
			led_out <= on_in | (blink_in & ph_q);
		end
	end
endmodule : ats_blink
`default_nettype wire

// ===== logic/ats_pkg.sv
// shared constants and types for the acquisition trigger sequencer
package ats_pkg;

	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] ATS_OFS_CTRL   = 8'h00; // arm, rearm
	localparam logic [7:0] ATS_OFS_PRE    = 8'h04; // pre-trigger count
	localparam logic [7:0] ATS_OFS_POST   = 8'h08; // post-trigger count
	localparam logic [7:0] ATS_OFS_PSTOP  = 8'h0C; // post-stop count
	localparam logic [7:0] ATS_OFS_NORM   = 8'h10; // normal interval
	localparam logic [7:0] ATS_OFS_ACQ    = 8'h14; // acquisition interval
	localparam logic [7:0] ATS_OFS_STB    = 8'h18; // status byte
	localparam logic [7:0] ATS_OFS_ESW    = 8'h1C; // event status word
	localparam logic [7:0] ATS_OFS_RDPTR  = 8'h20; // host read pointer
	localparam logic [7:0] ATS_OFS_BLOCK  = 8'h24; // block start / readable
	localparam logic [7:0] ATS_OFS_STAMP  = 8'h28; // trigger time stamp
	localparam logic [7:0] ATS_OFS_STOPTS = 8'h2C; // stop time stamp
	localparam logic [7:0] ATS_OFS_WRPTR  = 8'h30; // write pointer, count

	// field positions
	localparam int ATS_CTRL_ARM   = 0;
	localparam int ATS_CTRL_REARM = 1;
	localparam int ATS_STB_TRIG   = 1;
	localparam int ATS_ESW_DONE   = 0;
	localparam int ATS_ESW_STOP   = 1;
	localparam int ATS_ESW_OVR    = 2;

	// pre-trigger count meaning keep every scan
	localparam logic [31:0] ATS_PRE_ALL = 32'hFFFF_FFFF;

	// blink half period of the trigger indicator
	localparam int ATS_BLINK_MS  = 250;
	localparam int ATS_CLK_KHZ   = 50_000;
	localparam int ATS_BLINK_CYC = ATS_BLINK_MS * ATS_CLK_KHZ;

	localparam logic [1:0] ATS_RESP_OK  = 2'h0;
	localparam logic [1:0] ATS_RESP_ERR = 2'h2;

	typedef enum logic [1:0] {
		ATS_IDLE, ATS_PRE, ATS_POST, ATS_PSTOP
	} ats_state_t;

	// one scan record leaving the sequencer toward the buffer
	typedef struct packed {
		logic        valid;
		logic        post;   // taken after the trigger
		logic        stamp;  // time-stamped scan
	} ats_scan_t;

endpackage : ats_pkg

// ===== logic/ats_seq.sv
// acquisition trigger sequencer with axi4-lite register slave
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - nonzero pre count: pre scans start at normal interval after arming
// - at trigger keep newest pre scans, up to the count
// - pre count zero stores no pre scans
// - pre scans unreadable by host until trigger
// - triggered flag stays clear while waiting for trigger
// - post scans at acquisition interval until stop, unlimited; a zero post count ends after the trigger scan
// - post state shown by triggered set and stop flag clear
// - nonzero post-stop count takes exactly that many after stop; none taken when post count is zero
// - after last post-stop scan set complete, idle unless rearm
// - post-stop zero goes idle at stop unless rearm
// - post-stop state shown by stop set and complete clear
// - indicator blinks waiting, steady on in post and post-stop
// - alarm outputs update at the scan rate in use
// - interval switches to acquisition at the trigger
// - pre count minus one keeps every pre scan
// - pre count zero or more caps pre scans kept
// - rearm stores each cycle as its own trigger block
// - one acquisition forms one block with exactly one trigger
// - trigger stops pre scans, stamps first post scan, sets flag
// - stop stamps stop scan, clears triggered flag, indicator stays on until post-stop ends
// - rearm watches for a new trigger at once, same setup
module ats_seq
	import ats_pkg::*;
#(
	parameter int AW    = 10,          // buffer address width
	parameter int BLINK = ATS_BLINK_CYC
) (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// axi4-lite write
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// events from trigger detection
	input  wire logic        trig_in,
	input  wire logic        stop_in,
	// scan strobe toward converter and alarm logic
	output ats_scan_t        scan_out,
	output logic [AW-1:0]    scan_addr_out,
	output logic             alarm_upd_out,
	// front panel indicator
	output logic             trig_led_out
);
	localparam int DEPTH = 1 << AW;

	ats_state_t  st_q;
	logic        arm_q, rearm_q;
	logic [31:0] pre_q, post_q, pstop_q, norm_q, acq_q;
	logic [7:0]  stb_q;
	logic [7:0]  esw_q;
	logic [AW-1:0] wptr_q, rptr_q, blk_q;
	logic [31:0] pre_n_q, post_n_q, ps_n_q, time_q, tts_q, sts_q;
	logic        stamp_q, stop_seen_q;
	logic [31:0] rd_d;
	logic        tick;

	// bus write decode: both channels present, slave idle
	wire do_wr  = s_awvalid & s_wvalid & ~s_bvalid;
	wire do_rd  = s_arvalid & ~s_rvalid;
	wire wr_ctl = do_wr & (s_awaddr == ATS_OFS_CTRL);
	wire wr_cfg = do_wr & (st_q == ATS_IDLE);
	wire wr_rp  = do_wr & (s_awaddr == ATS_OFS_RDPTR);

	// scan in progress and interval choice
	// interval swap at trigger
	wire         run    = (st_q != ATS_IDLE);
	wire [31:0]  period = (st_q == ATS_PRE) ? norm_q : acq_q;
	wire         fire   = run & tick;
	wire         pre_store = (pre_q != 32'h0000_0000);
	// minus one keeps all, no cap
	wire         pre_cap   = (pre_q != ATS_PRE_ALL) &&
	                         (pre_n_q >= pre_q);
	wire         post_zero = (post_q == 32'h0000_0000);
	wire         ps_zero   = (pstop_q == 32'h0000_0000);
	wire         ps_last   = (ps_n_q + 32'h0000_0001 >= pstop_q);
	wire         full      = (wptr_q + 1'b1 == rptr_q);
	// a scan is written unless the buffer is full or it is a pre scan nobody asked for
	wire         store     = fire & ~full &
	                         ~((st_q == ATS_PRE) & ~pre_store);
	wire [AW-1:0] wptr_nx  = wptr_q + AW'(store);
	// host may not move its pointer into the hidden pre scans
	wire         rp_ok     = (st_q != ATS_PRE) |
	                         (AW'(s_wdata[AW-1:0] - rptr_q) <=
	                          AW'(blk_q - rptr_q));

	ats_tick #(.W(32)) u_tick (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.run_in      (run),
		.period_in   (period),
		.tick_out    (tick)
	);

	// blink while waiting, steady when triggered
	ats_blink #(.HALF(BLINK)) u_blink (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.blink_in    (st_q == ATS_PRE),
		.on_in       ((st_q == ATS_POST) | (st_q == ATS_PSTOP)),
		.led_out     (trig_led_out)
	);

	// axi4-lite handshake; ready and answer both come one cycle after the request
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= ATS_RESP_OK;
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= ATS_RESP_OK;
		end else begin
			s_awready <= do_wr & ~s_awready;
			s_wready  <= do_wr & ~s_awready;
			if (do_wr & ~s_awready) begin
				s_bvalid <= 1'b1;
				s_bresp  <= (s_awaddr > ATS_OFS_WRPTR) ?
				            ATS_RESP_ERR : ATS_RESP_OK;
			end else if (s_bready)
				s_bvalid <= 1'b0;
			s_arready <= do_rd & ~s_arready;
			if (do_rd & ~s_arready) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_d;
				s_rresp  <= (s_araddr > ATS_OFS_WRPTR) ?
				            ATS_RESP_ERR : ATS_RESP_OK;
			end else if (s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// read mux; block start doubles as the readable limit
	always_comb begin
		unique case (s_araddr)
			ATS_OFS_CTRL:   rd_d = {30'h0, rearm_q, arm_q};
			ATS_OFS_PRE:    rd_d = pre_q;
			ATS_OFS_POST:   rd_d = post_q;
			ATS_OFS_PSTOP:  rd_d = pstop_q;
			ATS_OFS_NORM:   rd_d = norm_q;
			ATS_OFS_ACQ:    rd_d = acq_q;
			ATS_OFS_STB:    rd_d = {24'h0, stb_q};
			ATS_OFS_ESW:    rd_d = {24'h0, esw_q};
			ATS_OFS_RDPTR:  rd_d = 32'(rptr_q);
			ATS_OFS_BLOCK:  rd_d = 32'(blk_q);
			ATS_OFS_STAMP:  rd_d = tts_q;
			ATS_OFS_STOPTS: rd_d = sts_q;
			ATS_OFS_WRPTR:  rd_d = 32'(wptr_q);
			default:        rd_d = 32'h0000_0000;
		endcase
	end

	// configuration registers, writable only while idle; rearm writable at any time
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			pre_q   <= 32'h0000_0000;
			post_q  <= 32'h0000_0000;
			pstop_q <= 32'h0000_0000;
			norm_q  <= 32'h0000_0000;
			acq_q   <= 32'h0000_0000;
			rearm_q <= 1'b0;
		end else begin
			if (wr_cfg & (s_awaddr == ATS_OFS_PRE))   pre_q   <= s_wdata;
			if (wr_cfg & (s_awaddr == ATS_OFS_POST))  post_q  <= s_wdata;
			if (wr_cfg & (s_awaddr == ATS_OFS_PSTOP)) pstop_q <= s_wdata;
			if (wr_cfg & (s_awaddr == ATS_OFS_NORM))  norm_q  <= s_wdata;
			if (wr_cfg & (s_awaddr == ATS_OFS_ACQ))   acq_q   <= s_wdata;
			// rearm may be dropped any time to end re-arming
			if (wr_ctl) rearm_q <= s_wdata[ATS_CTRL_REARM];
		end
	end

	// host read pointer; cannot pass block start while pre-trigger
	// hide pre scans until the trigger
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in)
			rptr_q <= '0;
		else if (wr_rp & rp_ok)
			rptr_q <= s_wdata[AW-1:0];
	end

	// free running time base for stamps
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in)
			time_q <= 32'h0000_0000;
		else
			time_q <= time_q + 32'h0000_0001;
	end

	// sequencer state machine
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_q     <= ATS_IDLE;
			arm_q    <= 1'b0;
			stb_q    <= 8'h00;
			esw_q    <= 8'h00;
			wptr_q   <= '0;
			blk_q    <= '0;
			pre_n_q  <= 32'h0000_0000;
			post_n_q <= 32'h0000_0000;
			ps_n_q   <= 32'h0000_0000;
			tts_q    <= 32'h0000_0000;
			sts_q    <= 32'h0000_0000;
			stamp_q  <= 1'b0;
			stop_seen_q <= 1'b0;
		end else begin
			// stamp waits for the next stored scan
			if (store)
				stamp_q <= 1'b0;
			// overrun sticks; set wins over a clear write
			if (fire & full)
				esw_q[ATS_ESW_OVR] <= 1'b1;
			else if (do_wr & (s_awaddr == ATS_OFS_ESW) &
			         s_wdata[ATS_ESW_OVR])
				esw_q[ATS_ESW_OVR] <= 1'b0;
			if (store)
				wptr_q <= wptr_nx;
			unique case (st_q)
				ATS_IDLE: begin
					if (wr_ctl & s_wdata[ATS_CTRL_ARM]) begin
						st_q    <= ATS_PRE;
						arm_q   <= 1'b1;
						esw_q[ATS_ESW_DONE] <= 1'b0;
						esw_q[ATS_ESW_STOP] <= 1'b0;
						pre_n_q <= 32'h0000_0000;
						blk_q   <= wptr_q;
					end
				end
				ATS_PRE: begin
					stb_q[ATS_STB_TRIG] <= 1'b0;
					// ring of newest scans: drop oldest once capped
					if (store) begin
						if (pre_cap)
							blk_q <= blk_q + 1'b1;
						else
							pre_n_q <= pre_n_q + 32'h0000_0001;
					end
					// trigger: stamp, set flag, go post
					if (trig_in) begin
						st_q     <= ATS_POST;
						stb_q[ATS_STB_TRIG] <= 1'b1;
						// a rearmed cycle starts with clean events
						esw_q[ATS_ESW_STOP] <= 1'b0;
						esw_q[ATS_ESW_DONE] <= 1'b0;
						tts_q    <= time_q;
						post_n_q <= 32'h0000_0000;
						stamp_q  <= 1'b1;
					end
				end
				ATS_POST: begin
					// scan until stop, no count limit
					if (fire)
						post_n_q <= post_n_q + 32'h0000_0001;
					// zero post count ends after trigger scan
					if (stop_in | (post_zero & fire)) begin
						stb_q[ATS_STB_TRIG] <= 1'b0;
						sts_q   <= time_q;
						esw_q[ATS_ESW_STOP] <= 1'b1;
						ps_n_q  <= 32'h0000_0000;
						if (!ps_zero & !post_zero) begin
							st_q    <= ATS_PSTOP;
							stamp_q <= 1'b1;
						end else begin
							esw_q[ATS_ESW_DONE] <= 1'b1;
							st_q  <= rearm_q ? ATS_PRE : ATS_IDLE;
							arm_q <= rearm_q;
							blk_q <= wptr_nx;
							stamp_q <= 1'b0;
							pre_n_q <= 32'h0000_0000;
						end
					end
				end
				ATS_PSTOP: begin
					if (fire) begin
						ps_n_q <= ps_n_q + 32'h0000_0001;
						// rearm: back to waiting, same setup
						// new block starts after this one
						if (ps_last) begin
							esw_q[ATS_ESW_DONE] <= 1'b1;
							st_q  <= rearm_q ? ATS_PRE : ATS_IDLE;
							arm_q <= rearm_q;
							blk_q <= wptr_nx;
							stamp_q <= 1'b0;
							pre_n_q <= 32'h0000_0000;
						end
					end
				end
			endcase
		end
	end

	// scan strobe and alarm update follow the active tick
	// alarm refresh at scan rate
	// scans tagged by phase of the one block
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			scan_out      <= '0;
			scan_addr_out <= '0;
			alarm_upd_out <= 1'b0;
		end else begin
			scan_out.valid <= store;
			scan_out.post  <= (st_q != ATS_PRE);
			scan_out.stamp <= stamp_q;
			scan_addr_out  <= wptr_q;
			alarm_upd_out  <= fire;
		end
	end

	// checks
	chk_post_flags: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_POST) |->
		stb_q[ATS_STB_TRIG] && !esw_q[ATS_ESW_STOP])
		else $error("post flags wrong");
	chk_pstop_flags: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_PSTOP) |->
		esw_q[ATS_ESW_STOP] && !esw_q[ATS_ESW_DONE])
		else $error("post-stop flags wrong");
	chk_trig_flag: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_PRE && trig_in) |=>
		stb_q[ATS_STB_TRIG] && st_q == ATS_POST)
		else $error("trigger not taken");
	chk_wait_flag: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) ##1 (st_q == ATS_PRE &&
		$past(st_q) == ATS_PRE) |-> !stb_q[ATS_STB_TRIG])
		else $error("triggered while waiting");
	chk_stop_clear: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_POST && stop_in) |=>
		!stb_q[ATS_STB_TRIG] && esw_q[ATS_ESW_STOP])
		else $error("stop not handled");
	chk_rearm_back: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_PSTOP && fire && ps_last
		&& rearm_q) |=> st_q == ATS_PRE)
		else $error("no rearm");
	chk_idle_done: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) (st_q == ATS_PSTOP && fire && ps_last
		&& !rearm_q) |=> st_q == ATS_IDLE && esw_q[ATS_ESW_DONE])
		else $error("no completion");
	chk_alarm_rate: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in) fire |=> alarm_upd_out)
		else $error("alarm update missed");
	cov_trig: cover property (@(posedge core_clk_in)
		st_q == ATS_PRE ##1 st_q == ATS_POST);
	cov_pstop: cover property (@(posedge core_clk_in)
		st_q == ATS_POST ##1 st_q == ATS_PSTOP);
	cov_rearm: cover property (@(posedge core_clk_in)
		st_q == ATS_PSTOP ##1 st_q == ATS_PRE);
endmodule : ats_seq
`default_nettype wire

// ===== logic/ats_tick.sv
// scan interval tick generator, one-cycle enable per interval
`timescale 1ns/1ps
`default_nettype none
module ats_tick
	import ats_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         resetn_in,
	// control
	input  wire logic         run_in,
	input  wire logic [W-1:0] period_in,
	// tick
	output logic              tick_out
);
	logic [W-1:0] cnt_q;
	wire          wrap = (cnt_q == '0);

	// reload on wrap; a period of zero ticks every cycle
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || !run_in) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= wrap;
			cnt_q    <= wrap ? period_in : cnt_q - 1'b1;
		end
	end
endmodule : ats_tick
`default_nettype wire

// ===== sim/ats_host.sv
// host model: axi4-lite master that programs and polls the sequencer
`timescale 1ns/1ps
`default_nettype none
module ats_host (
	// clock
	input  wire logic        core_clk_in,
	// write channels
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	// read channels
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	// quiet bus from time zero
	initial begin
		awaddr_out = 8'h00;
		awvalid_out = 1'b0;
		wdata_out = 32'h0;
		wvalid_out = 1'b0;
		bready_out = 1'b0;
		araddr_out = 8'h00;
		arvalid_out = 1'b0;
		rready_out = 1'b0;
	end

	// one write; address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_on;
		logic w_on;
		logic done;
		@(posedge core_clk_in);
		awaddr_out <= a;
		wdata_out <= d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		aw_on = 1'b1;
		w_on = 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge core_clk_in);
			if (aw_on && awready_in) begin
				awvalid_out <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && wready_in) begin
				wvalid_out <= 1'b0;
				w_on = 1'b0;
			end
			if (bvalid_in) begin
				r = bresp_in;
				bready_out <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	// one read; status is polled often so data never waits long
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_on;
		@(posedge core_clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		ar_on = 1'b1;
		do begin
			@(posedge core_clk_in);
			if (ar_on && arready_in) begin
				arvalid_out <= 1'b0;
				ar_on = 1'b0;
			end
		end while (!rvalid_in);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask : rd
endmodule : ats_host
`default_nettype wire

// ===== sim/test_acquisition_trigger_sequencer.sv
// self-checking bench for the acquisition trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module test_acquisition_trigger_sequencer
	import ats_pkg::*;
;
	localparam int AW = 6;
	localparam int BLINK = 8;
	// clock, reset and events
	logic            core_clk_in = 1'b0;
	logic            resetn_in;
	logic            trig_in;
	logic            stop_in;
	// bus and design outputs
	logic [7:0]      awaddr, araddr;
	logic            awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready;
	logic [31:0]     wdata, rdata, seed, norm, acq, rdv;
	logic [1:0]      bresp, rresp, rsp;
	ats_scan_t       scan;
	logic [AW-1:0]   scan_addr, wa;
	logic            alarm_upd, led, led_q;
	// bench state
	int              mismatches, compares, cyc, last_cyc;
	int              n_pre, n_post, n_ps, n_alarm, tog;
	logic            last_post, last_ok, gap_chk, ps_arm, ps_on;

	always #10 core_clk_in = ~core_clk_in;

	ats_host host (.core_clk_in(core_clk_in),
		.awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready),
		.bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
		.araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
		.rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
		.rready_out(rready));

	ats_seq #(.AW(AW), .BLINK(BLINK)) dut (.core_clk_in(core_clk_in),
		.resetn_in(resetn_in), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.trig_in(trig_in), .stop_in(stop_in), .scan_out(scan),
		.scan_addr_out(scan_addr), .alarm_upd_out(alarm_upd),
		.trig_led_out(led));

	task automatic give_verdict;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		host.rd(a, rdv, rsp);
		chk(rdv & m, e);
	endtask : rdc

	// scan spacing follows the interval of the state in use
	function automatic logic [31:0] exp_gap(input logic p);
		return p ? acq + 32'h1 : norm + 32'h1;
	endfunction : exp_gap

	task automatic clr;
		n_pre = 0;
		n_post = 0;
		n_ps = 0;
		n_alarm = 0;
		tog = 0;
		last_ok = 1'b0;
		ps_arm = 1'b0;
		ps_on = 1'b0;
	endtask : clr

	// one-cycle event pulse, 1 = trigger, 0 = stop
	task automatic pulse(input logic t);
		@(posedge core_clk_in);
		if (t)
			trig_in <= 1'b1;
		else
			stop_in <= 1'b1;
		@(posedge core_clk_in);
		trig_in <= 1'b0;
		stop_in <= 1'b0;
	endtask : pulse

	// watchdog plus scan, alarm and indicator counting
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			give_verdict();
		end
		led_q <= led;
		if (led !== led_q)
			tog++;
		if (alarm_upd === 1'b1)
			n_alarm++;
		if (scan.valid === 1'b1) begin
			if (scan.post)
				n_post++;
			else
				n_pre++;
			// the stamped stop scan opens the post-stop count
			if (scan.stamp && ps_arm)
				ps_on = 1'b1;
			if (ps_on && scan.post)
				n_ps++;
			// scans land at consecutive buffer addresses
			chk(32'(scan_addr), 32'(wa));
			wa = wa + 1'b1;
			if (gap_chk && last_ok && !scan.stamp && last_post === scan.post)
				chk(cyc - last_cyc, exp_gap(scan.post));
			last_ok = !scan.stamp;
			last_post = scan.post;
			last_cyc = cyc;
		end
	end

	// one acquisition from a fresh reset, intervals drawn at random
	task automatic run(input logic [31:0] pre, input logic [31:0] post,
		input logic [31:0] pstop, input logic re);
		@(posedge core_clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		wa = '0;
		resetn_in <= 1'b1;
		norm = {$random(seed)} % 4 + 2;
		acq = {$random(seed)} % 3 + 1;
		// pre waits kept short so even keep-all fits the buffer
		host.wr(ATS_OFS_PRE, pre, rsp);
		host.wr(ATS_OFS_POST, post, rsp);
		host.wr(ATS_OFS_PSTOP, pstop, rsp);
		host.wr(ATS_OFS_NORM, norm, rsp);
		host.wr(ATS_OFS_ACQ, acq, rsp);
		clr();
		gap_chk = 1'b1;
		host.wr(ATS_OFS_CTRL, {30'h0, re, 1'b1}, rsp);
		chk(rsp, ATS_RESP_OK);
		// refused while acquiring, so the gap check still expects norm
		host.wr(ATS_OFS_NORM, 32'h9, rsp);
		repeat (40) @(posedge core_clk_in);
		rdc(ATS_OFS_STB, 32'h2, 32'h0);
		chk(tog > 2, 1);
		chk(n_alarm > 0, 1);
		chk(n_pre, pre == 0 ? 0 : n_alarm);
		// a pointer past the block start is refused while waiting
		host.wr(ATS_OFS_RDPTR, 32'h3F, rsp);
		rdc(ATS_OFS_RDPTR, 32'h3F, 32'h0);
		clr();
		pulse(1'b1);
		repeat (10) @(posedge core_clk_in);
		tog = 0;
		n_pre = 0;
		repeat (20) @(posedge core_clk_in);
		// a zero post count has already ended at the trigger scan
		rdc(ATS_OFS_STB, 32'h2, post == 0 ? 32'h0 : 32'h2);
		rdc(ATS_OFS_ESW, 32'h2, post == 0 ? 32'h2 : 32'h0);
		chk({tog[7:0], led}, post == 0 ? 9'h0 : 9'h1);
		chk(n_pre, 0);
		chk(post == 0 ? n_post == 1 : n_post > 3, 1);
		gap_chk = 1'b0;
		ps_arm = 1'b1;
		pulse(1'b0);
		if (post != 0 && pstop != 0) begin
			rdc(ATS_OFS_ESW, 32'h3, 32'h2);
			rdc(ATS_OFS_STB, 32'h2, 32'h0);
		end
		repeat (120) @(posedge core_clk_in);
		chk(n_ps, post == 0 ? 0 : pstop);
		rdc(ATS_OFS_ESW, 32'h1, 32'h1);
		tog = 0;
		repeat (40) @(posedge core_clk_in);
		if (re) begin
			chk(tog > 2, 1);
			pulse(1'b1);
			repeat (10) @(posedge core_clk_in);
			rdc(ATS_OFS_STB, 32'h2, 32'h2);
		end else
			chk({tog[7:0], led}, 9'h0);
	endtask : run

	// reset, then the corner cases of the counts
	initial begin
		resetn_in = 1'b0;
		trig_in = 1'b0;
		stop_in = 1'b0;
		mismatches = 0;
		compares = 0;
		cyc = 0;
		seed = 32'h839B;
		gap_chk = 1'b0;
		wa = '0;
		clr();
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		@(posedge core_clk_in);
		chk({scan, alarm_upd, led}, 32'h0);
		rdc(ATS_OFS_STB, 32'hFFFF_FFFF, 32'h0);
		host.rd(8'h34, rdv, rsp);
		chk(rsp, ATS_RESP_ERR);
		chk(rdv, 32'h0);
		run(32'h3, 32'h5, 32'h4, 1'b0);
		run(32'h0, 32'h5, 32'h0, 1'b0);
		run(ATS_PRE_ALL, 32'h0, 32'h3, 1'b0);
		run(32'h2, 32'h4, 32'h3, 1'b1);
		give_verdict();
	end
endmodule : test_acquisition_trigger_sequencer
`default_nettype wire
